// ===== verif/pss_host_model.sv
`timescale 1ns/1ps
module pss_host_model (
    // device side of the link
    input  wire logic i_txd,
    input  wire logic i_host_busy,
    // host drive
    output logic      o_rxd
);
    // host stays at mark; a frame takes too long for this run
    assign o_rxd = 1'b1;
endmodule // pss_host_model

// ===== verif/pss_serial_port_cfg_assertions.sv
`timescale 1ns/1ps
module pss_cfg_chk (
    input wire logic       i_clock,
    input wire logic       i_arst_n,
    input wire logic       i_line_key,
    input wire logic       i_head_open,
    input wire logic [7:0] i_serial_switch_bank,
    input wire logic [7:0] i_operation_switch_bank_a,
    input wire logic       o_host_busy,
    input wire logic       o_online,
    input wire logic       o_print_run,
    input wire logic       o_feed_blank,
    input wire logic       o_reprint,
    input wire logic       o_sensor_reflective,
    input wire logic       o_head_check_en
);
    // cycles since reset; switch capture is long over at 15
    logic [3:0] age;
    always_ff @(posedge i_clock or negedge i_arst_n)
        if (!i_arst_n) age <= 4'h0;
        else if (age != 4'hF) age <= age + 4'h1;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    a_switch_held: assert property (age == 4'hF |->
        $stable(o_sensor_reflective) && $stable(o_head_check_en))
        else $error("switch outputs moved after power-up");
    a_sensor_select: assert property (age == 4'hF |->
        o_sensor_reflective == i_operation_switch_bank_a[1])
        else $error("sensor select wrong");
    a_headck_select: assert property (age == 4'hF |->
        o_head_check_en == i_operation_switch_bank_a[2])
        else $error("head check enable wrong");
    a_line_toggle: assert property ($rose(i_line_key) |->
        ##[1:6] !$stable(o_online)) else $error("line key ignored");
    a_print_online: assert property (o_print_run |-> o_online)
        else $error("printing while off-line");
    a_head_stop: assert property (i_head_open [*4] |->
        !o_print_run) else $error("printing with head open");
    a_blank_offline: assert property (o_feed_blank |-> !o_online)
        else $error("blank feed while on-line");
    a_reprint_online: assert property (o_reprint |-> o_online)
        else $error("reprint while off-line");
    a_busy_offline: assert property (!o_online &&
        i_serial_switch_bank[7:6] == 2'h0 |-> ##[0:3] o_host_busy)
        else $error("not busy while off-line");
endmodule // pss_cfg_chk
bind pss_serial_port_cfg pss_cfg_chk u_pss_cfg_chk (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_line_key(i_line_key),
    .i_head_open(i_head_open), .i_serial_switch_bank(i_serial_switch_bank),
    .i_operation_switch_bank_a(i_operation_switch_bank_a),
    .o_host_busy(o_host_busy), .o_online(o_online),
    .o_print_run(o_print_run), .o_feed_blank(o_feed_blank),
    .o_reprint(o_reprint), .o_sensor_reflective(o_sensor_reflective),
    .o_head_check_en(o_head_check_en));

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
    import pss_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, hd = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, rq;
    logic [7:0] ssw = 8'h00, swa = 8'h00, s;
    logic [1:0] key = 2'h0;
    logic wt, irq, rxd, txd, busy, online, run, blank, rep, refl, hck, fb;
    logic fr;
    int num_errors = 0, comparisons = 0;
    always #2.5 clk = ~clk;
    pss_serial_port_cfg u_pss_serial_port_cfg (.i_clock(clk),
        .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wt), .o_irq(irq), .i_serial_switch_bank(ssw),
        .i_operation_switch_bank_a(swa), .i_operation_switch_bank_b(8'h00),
        .i_line_key(key[0]), .i_feed_key(key[1]), .i_head_open(hd),
        .i_rxd(rxd), .o_txd(txd), .o_host_busy(busy), .o_online(online),
        .o_print_run(run), .o_feed_blank(blank), .o_reprint(rep),
        .o_sensor_reflective(refl), .o_head_check_en(hck));
    pss_host_model u_pss_host_model (.i_txd(txd), .i_host_busy(busy),
        .o_rxd(rxd));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 20);
        rq = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wt !== 1'b0) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic boot(logic [7:0] sb, logic [7:0] ab);
        ssw <= sb;
        swa <= ab;
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
    // key press long enough for the sync chain; catches blank pulses
    task automatic press(int k);
        fb = 1'b0;
        fr = 1'b0;
        key[k] <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            fb = fb | blank;
            fr = fr | rep;
        end
        key[k] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_switches();
        for (int i = 0; i < 4; i++) begin
            s = 8'(8'h55 * i);
            boot(s, {5'h00, i[1:0], 1'b0});
            ssw <= s ^ 8'h3F; // moved while running, must not count
            bus(1'b0, PSS_REG_CONFIG, 32'h0);
            chk("config", {16'h0, 5'h00, i[1:0], 1'b0, s}, rq);
            chk("sensor", i[0], refl);
            chk("headck", i[1], hck);
            chk("busy up", 0, busy);
            chk("txd", i != 2, txd);
            press(0);
            chk("online", 0, online);
            chk("busy", i == 0 || i == 3, busy);
        end
        $display("switch test done");
    endtask
    task automatic t_keys_irq();
        boot(8'h00, 8'h00);
        press(1);
        chk("blank on-line", 0, fb);
        chk("reprint on-line", 1, fr);
        chk("irq masked", 0, irq);
        bus(1'b1, PSS_REG_IRQ_MASK, 32'h1 << PSS_IRQ_FEED);
        repeat (2) @(posedge clk);
        chk("irq set", 1, irq);
        bus(1'b1, PSS_REG_IRQ_STAT, 32'h1 << PSS_IRQ_FEED);
        repeat (2) @(posedge clk);
        chk("irq clear", 0, irq);
        press(0);
        press(1);
        chk("blank off-line", 1, fb);
        chk("reprint off-line", 0, fr);
        bus(1'b0, 5'h1C, 32'h0);
        chk("unmapped", 0, rq);
        $display("key test done");
    endtask
    task automatic t_print();
        press(0);
        bus(1'b1, PSS_REG_CONTROL, 32'h1);
        repeat (2) @(posedge clk);
        chk("run", 1, run);
        hd <= 1'b1;
        repeat (6) @(posedge clk);
        chk("run head open", 0, run);
        hd <= 1'b0;
        repeat (6) @(posedge clk);
        chk("run resumed", 1, run);
        press(0);
        chk("run paused", 0, run);
        $display("print test done");
    endtask
    initial begin
        t_switches();
        t_keys_irq();
        t_print();
        tally_and_finish();
    end
endmodule // tb

// ===== verilog/pss_pkg.sv
package pss_pkg;
    // clock and oversampling
    localparam int unsigned PSS_CLK_HZ     = 200_000_000;
    localparam int unsigned PSS_OVERSAMPLE = 16;
    localparam logic [15:0] PSS_DIV_9600  =
        16'(PSS_CLK_HZ / (PSS_OVERSAMPLE * 9600));
    localparam logic [15:0] PSS_DIV_19200 =
        16'(PSS_CLK_HZ / (PSS_OVERSAMPLE * 19200));
    localparam logic [15:0] PSS_DIV_4800  =
        16'(PSS_CLK_HZ / (PSS_OVERSAMPLE * 4800));
    localparam logic [15:0] PSS_DIV_2400  =
        16'(PSS_CLK_HZ / (PSS_OVERSAMPLE * 2400));
    localparam logic [3:0]  PSS_MID_TICK  = 4'h7;
    localparam logic [3:0]  PSS_LAST_TICK = 4'hF;
    localparam logic [1:0]  PSS_SETTLE    = 2'h3;
    // serial bank switch positions (switch n at bit n-1)
    localparam int PSS_SW_DATA7  = 0;
    localparam int PSS_SW_PAR_A  = 1;
    localparam int PSS_SW_PAR_B  = 2;
    localparam int PSS_SW_STOP2  = 3;
    localparam int PSS_SW_BAUD_A = 4;
    localparam int PSS_SW_BAUD_B = 5;
    localparam int PSS_SW_FLOW_A = 6;
    localparam int PSS_SW_FLOW_B = 7;
    // operation bank a switch positions
    localparam int PSS_SW_SENSOR = 1;
    localparam int PSS_SW_HEADCK = 2;
    // two-switch selector codes {first, second}
    localparam logic [1:0] PSS_SEL_OFF_ON = 2'h1;
    localparam logic [1:0] PSS_SEL_ON_OFF = 2'h2;
    localparam logic [1:0] PSS_SEL_ON_ON  = 2'h3;
    typedef enum logic [1:0] {
        PSS_FLOW_RDYBSY = 2'b00,
        PSS_FLOW_XONOFF = 2'b01,
        PSS_FLOW_BIDIR  = 2'b10
    } pss_flow_t;
    localparam logic [7:0] PSS_XON  = 8'h11;
    localparam logic [7:0] PSS_XOFF = 8'h13;
    // register byte offsets
    localparam logic [4:0] PSS_REG_CONFIG   = 5'h00;
    localparam logic [4:0] PSS_REG_CONTROL  = 5'h04;
    localparam logic [4:0] PSS_REG_STATE    = 5'h08;
    localparam logic [4:0] PSS_REG_IRQ_STAT = 5'h0C;
    localparam logic [4:0] PSS_REG_IRQ_MASK = 5'h10;
    localparam logic [4:0] PSS_REG_RX_DATA  = 5'h14;
    localparam logic [4:0] PSS_REG_TX_DATA  = 5'h18;
    // interrupt bits
    localparam int PSS_IRQ_W       = 7;
    localparam int PSS_IRQ_RX      = 0;
    localparam int PSS_IRQ_PARITY  = 1;
    localparam int PSS_IRQ_FRAMING = 2;
    localparam int PSS_IRQ_OVERRUN = 3;
    localparam int PSS_IRQ_LINE    = 4;
    localparam int PSS_IRQ_FEED    = 5;
    localparam int PSS_IRQ_HEAD    = 6;
    // reset values
    localparam logic       PSS_ONLINE_RST = 1'b1;
    localparam logic [7:0] PSS_BANK_RST   = 8'h00;
endpackage

// ===== verilog/pss_rx.sv
`timescale 1ns/1ps
module pss_rx (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    // oversample tick and synchronised line
    input  wire logic       i_tick,
    input  wire logic       i_rxd,
    // character format
    input  wire logic       i_data7,
    input  wire logic       i_par_en,
    input  wire logic       i_par_odd,
    input  wire logic       i_stop2,
    // received character
    output logic            o_done,
    output logic [7:0]      o_data,
    output logic            o_par_err,
    output logic            o_frm_err
);
    import pss_pkg::*;
    typedef enum logic [2:0] {
        PSS_RX_IDLE = 3'b000, PSS_RX_START = 3'b001, PSS_RX_DATA = 3'b010,
        PSS_RX_PAR  = 3'b011, PSS_RX_STOP  = 3'b100
    } pss_rx_state_t;
    pss_rx_state_t state;
    logic [3:0] tick_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic       par_acc, par_bad, frm_bad, stop_left;
    wire        sample   = i_tick && tick_cnt == PSS_LAST_TICK;
    wire [2:0]  last_bit = i_data7 ? 3'h6 : 3'h7;
    // bits are sampled at mid-cell, sixteen ticks apart
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= PSS_RX_IDLE;
            tick_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            {par_acc, par_bad, frm_bad, stop_left} <= 4'h0;
            o_done <= 1'b0;
            o_data <= 8'h00;
            o_par_err <= 1'b0;
            o_frm_err <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_tick && state != PSS_RX_IDLE) begin
                tick_cnt <= tick_cnt + 4'h1;
            end
            case (state)
                PSS_RX_IDLE: if (i_tick && !i_rxd) begin
                    state <= PSS_RX_START;
                    tick_cnt <= 4'h0;
                end
                PSS_RX_START: if (i_tick && tick_cnt == PSS_MID_TICK) begin
                    // a glitch shorter than half a bit is not a start
                    state <= i_rxd ? PSS_RX_IDLE : PSS_RX_DATA;
                    tick_cnt <= 4'h0;
                    bit_cnt <= 3'h0;
                    {par_acc, par_bad, frm_bad} <= 3'h0;
                end
                PSS_RX_DATA: if (sample) begin
                    shift <= {i_rxd, shift[7:1]};
                    par_acc <= par_acc ^ i_rxd;
                    bit_cnt <= bit_cnt + 3'h1;
                    stop_left <= i_stop2;
                    if (bit_cnt == last_bit) begin
                        state <= i_par_en ? PSS_RX_PAR : PSS_RX_STOP;
                    end
                end
                PSS_RX_PAR: if (sample) begin
                    par_bad <= (par_acc ^ i_rxd) != i_par_odd;
                    state <= PSS_RX_STOP;
                end
                PSS_RX_STOP: if (sample) begin
                    if (!i_rxd) begin
                        frm_bad <= 1'b1;
                    end
                    if (stop_left) begin
                        stop_left <= 1'b0;
                    end else begin
                        state <= PSS_RX_IDLE;
                        o_done <= 1'b1;
                        o_data <= i_data7 ? {1'b0, shift[7:1]} : shift;
                        o_par_err <= par_bad;
                        o_frm_err <= frm_bad | !i_rxd;
                    end
                end
                default: state <= PSS_RX_IDLE;
            endcase
        end
    end
endmodule // pss_rx

// ===== verilog/pss_serial_port_cfg.sv
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module pss_serial_port_cfg (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    // avalon-mm slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    // switch banks, high = switch on
    input  wire logic [7:0]  i_serial_switch_bank,
    input  wire logic [7:0]  i_operation_switch_bank_a,
    input  wire logic [7:0]  i_operation_switch_bank_b,
    // panel keys and head switch, high = pressed / open
    input  wire logic        i_line_key,
    input  wire logic        i_feed_key,
    input  wire logic        i_head_open,
    // serial host link
    input  wire logic        i_rxd,
    output logic             o_txd,
    output logic             o_host_busy,
    // print engine controls
    output logic             o_online,
    output logic             o_print_run,
    output logic             o_feed_blank,
    output logic             o_reprint,
    output logic             o_sensor_reflective,
    output logic             o_head_check_en
);
    import pss_pkg::*;

    // bit-cell counters are four bits wide; a zero divisor ticks only every 65536 cycles
    if (PSS_OVERSAMPLE != 32'(PSS_LAST_TICK) + 32'h1 ||
        PSS_DIV_19200 == 16'h0000) begin : g_rate_chk
        $error("clock and oversample do not suit the bit-cell counters");
    end

    // two-flop synchronisers for every pin; rxd idles high
    localparam int NPIN = 28;
    localparam logic [NPIN-1:0] PIN_IDLE = 28'h0000001;
    wire  [NPIN-1:0] pin_raw = {i_serial_switch_bank,
        i_operation_switch_bank_a, i_operation_switch_bank_b,
        i_line_key, i_feed_key, i_head_open, i_rxd};
    logic [NPIN-1:0] pin_meta, pin_sync;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end
    // single pins, taken only from the second stage
    wire       s_rxd  = pin_sync[0];
    wire       s_head = pin_sync[1];
    wire       s_feed = pin_sync[2];
    wire       s_line = pin_sync[3];

    // switches are caught once after reset; later changes are ignored
    logic [1:0] settle;
    logic       cfg_taken;
    logic [7:0] serial_cfg, bank_a, bank_b;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settle <= 2'h0;
            cfg_taken <= 1'b0;
            serial_cfg <= PSS_BANK_RST;
            bank_a <= PSS_BANK_RST;
            bank_b <= PSS_BANK_RST;
        end else if (!cfg_taken) begin
            settle <= settle + 2'h1;
            if (settle == PSS_SETTLE) begin
                cfg_taken <= 1'b1;
                serial_cfg <= pin_sync[27:20];
                bank_a <= pin_sync[19:12];
                bank_b <= pin_sync[11:4];
            end
        end
    end

    // character format and rate decode
    wire [1:0] par_sel  = {serial_cfg[PSS_SW_PAR_A], serial_cfg[PSS_SW_PAR_B]};
    wire [1:0] baud_sel = {serial_cfg[PSS_SW_BAUD_A],
                           serial_cfg[PSS_SW_BAUD_B]};
    wire [1:0] flow_sel = {serial_cfg[PSS_SW_FLOW_A],
                           serial_cfg[PSS_SW_FLOW_B]};
    wire       data7    = serial_cfg[PSS_SW_DATA7];
    // the unused on/on parity code falls back to no parity
    wire       par_en   = par_sel == PSS_SEL_OFF_ON ||
                          par_sel == PSS_SEL_ON_OFF;
    wire       par_odd  = par_sel == PSS_SEL_ON_OFF;
    wire       stop2    = serial_cfg[PSS_SW_STOP2];
    wire [15:0] divisor =
        baud_sel == PSS_SEL_OFF_ON ? PSS_DIV_19200 :
        baud_sel == PSS_SEL_ON_OFF ? PSS_DIV_4800  :
        baud_sel == PSS_SEL_ON_ON  ? PSS_DIV_2400  : PSS_DIV_9600;
    // the unused on/on protocol code falls back to ready/busy
    wire [1:0] flow_code =
        flow_sel == PSS_SEL_OFF_ON ? PSS_FLOW_XONOFF :
        flow_sel == PSS_SEL_ON_OFF ? PSS_FLOW_BIDIR  : PSS_FLOW_RDYBSY;
    wire pss_flow_t flow = pss_flow_t'(flow_code);

    // oversample tick divider, held until the switches are known
    logic [15:0] div_cnt;
    wire         tick = cfg_taken && div_cnt == 16'h0000;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_cnt <= 16'h0000;
        end else if (cfg_taken) begin
            div_cnt <= tick ? divisor - 16'h0001 : div_cnt - 16'h0001;
        end
    end

    // key edges; the prev flops look only at the second sync stage
    logic line_prev, feed_prev, head_prev;
    wire  line_press = s_line && !line_prev;
    wire  feed_press = s_feed && !feed_prev;
    wire  head_rise  = s_head && !head_prev;
    logic online, job_active;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {line_prev, feed_prev, head_prev} <= 3'h0;
            online <= PSS_ONLINE_RST;
            o_feed_blank <= 1'b0;
            o_reprint <= 1'b0;
        end else begin
            {line_prev, feed_prev, head_prev} <= {s_line, s_feed, s_head};
            if (line_press) begin
                online <= !online;
            end
            // feed needs a closed head; the pulse lasts one cycle
            o_feed_blank <= feed_press && !online && !s_head;
            o_reprint <= feed_press && online && !s_head;
        end
    end
    // a paused job resumes when the line key brings it back on-line
    assign o_print_run = job_active && online && !s_head
                         && cfg_taken;
    assign o_online = online;
    assign o_sensor_reflective = bank_a[PSS_SW_SENSOR];
    assign o_head_check_en = bank_a[PSS_SW_HEADCK];

    // receiver and transmitter
    logic       rx_done, rx_par_err, rx_frm_err;
    logic [7:0] rx_byte;
    pss_rx u_rx (
        .i_clock   (i_clock),
        .i_arst_n  (i_arst_n),
        .i_tick    (tick),
        .i_rxd     (s_rxd),
        .i_data7   (data7),
        .i_par_en  (par_en),
        .i_par_odd (par_odd),
        .i_stop2   (stop2),
        .o_done    (rx_done),
        .o_data    (rx_byte),
        .o_par_err (rx_par_err),
        .o_frm_err (rx_frm_err)
    );
    // flow characters go out ahead of a waiting host byte
    logic       tx_busy, tx_start, tx_req, xon_pend, xoff_pend;
    logic [7:0] tx_hold;
    wire        flow_pend = xon_pend || xoff_pend;
    wire  [7:0] tx_byte = xoff_pend ? PSS_XOFF : xon_pend ? PSS_XON : tx_hold;
    assign tx_start = !tx_busy && (flow_pend || tx_req);
    pss_tx u_tx (
        .i_clock   (i_clock),
        .i_arst_n  (i_arst_n),
        .i_tick    (tick),
        .i_start   (tx_start),
        .i_data    (tx_byte),
        .i_data7   (data7),
        .i_par_en  (par_en),
        .i_par_odd (par_odd),
        .i_stop2   (stop2),
        .o_busy    (tx_busy),
        .o_txd     (o_txd)
    );

    // bus decode; reads answer on the second cycle
    logic rd_ack;
    wire  wr_lane0  = i_avs_write && i_avs_byteenable[0];
    wire  hit_ctrl  = i_avs_address == PSS_REG_CONTROL;
    wire  hit_stat  = i_avs_address == PSS_REG_IRQ_STAT;
    wire  hit_mask  = i_avs_address == PSS_REG_IRQ_MASK;
    wire  hit_rx    = i_avs_address == PSS_REG_RX_DATA;
    wire  hit_tx    = i_avs_address == PSS_REG_TX_DATA;
    // a transmit write stalls while the previous byte still waits
    wire  tx_stall  = i_avs_write && hit_tx && tx_req;
    assign o_avs_waitrequest = (i_avs_read && !rd_ack) || tx_stall;
    wire  wr_take   = wr_lane0 && !tx_stall;
    wire  rx_pop    = i_avs_read && rd_ack && hit_rx;

    // host data is taken only while on-line
    logic       rx_valid, host_busy, busy_prev;
    logic [7:0] rx_data;
    wire        rx_accept = rx_done && online;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            if (rx_accept) begin
                rx_data <= rx_byte;
                rx_valid <= 1'b1;                               // set wins
            end else if (rx_pop) begin
                rx_valid <= 1'b0;
            end
        end
    end

    // flow control: busy while off-line or a byte is unread
    wire busy_now = !online || rx_valid || !cfg_taken;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            host_busy <= 1'b1;
            busy_prev <= 1'b1;
            {xon_pend, xoff_pend, tx_req} <= 3'h0;
            tx_hold <= 8'h00;
            job_active <= 1'b0;
        end else begin
            host_busy <= busy_now && flow == PSS_FLOW_RDYBSY;
            busy_prev <= busy_now;
            if (flow == PSS_FLOW_XONOFF && cfg_taken
                && busy_now != busy_prev) begin
                xoff_pend <= busy_now;
                xon_pend <= !busy_now;
            end else if (tx_start && flow_pend) begin
                {xon_pend, xoff_pend} <= 2'h0;
            end
            if (wr_take && hit_tx) begin
                tx_hold <= i_avs_writedata[7:0];
                tx_req <= 1'b1;
            end else if (tx_start && !flow_pend) begin
                tx_req <= 1'b0;
            end
            if (wr_take && hit_ctrl) begin
                job_active <= i_avs_writedata[0];
            end
        end
    end
    assign o_host_busy = host_busy;

    // sticky events, cleared by writing one; a new event beats the clear
    logic [PSS_IRQ_W-1:0] irq_stat, irq_mask, irq_ev;
    always_comb begin
        irq_ev = '0;
        irq_ev[PSS_IRQ_RX]      = rx_accept;
        irq_ev[PSS_IRQ_PARITY]  = rx_accept && rx_par_err;
        irq_ev[PSS_IRQ_FRAMING] = rx_accept && rx_frm_err;
        irq_ev[PSS_IRQ_OVERRUN] = rx_accept && rx_valid && !rx_pop;
        irq_ev[PSS_IRQ_LINE]    = line_press;
        irq_ev[PSS_IRQ_FEED]    = feed_press;
        irq_ev[PSS_IRQ_HEAD]    = head_rise;
    end
    // only bits written as one are cleared
    wire [PSS_IRQ_W-1:0] irq_clr =
        (wr_take && hit_stat) ? i_avs_writedata[PSS_IRQ_W-1:0] : '0;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat <= '0;
            irq_mask <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (wr_take && hit_mask) begin
                irq_mask <= i_avs_writedata[PSS_IRQ_W-1:0];
            end
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // read data; unmapped offsets read zero
    wire [31:0] rd_mux =
        i_avs_address == PSS_REG_CONFIG ?
            {8'h00, bank_b, bank_a, serial_cfg} :
        hit_ctrl ? {31'h0, job_active} :
        i_avs_address == PSS_REG_STATE ?
            {25'h0, tx_req, tx_busy, rx_valid, host_busy, s_head,
             o_print_run, online} :
        hit_stat ? {{(32-PSS_IRQ_W){1'b0}}, irq_stat} :
        hit_mask ? {{(32-PSS_IRQ_W){1'b0}}, irq_mask} :
        hit_rx   ? {24'h0, rx_data} : 32'h0000_0000;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_ack <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            rd_ack <= i_avs_read && !rd_ack;
            if (i_avs_read && !rd_ack) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end
endmodule // pss_serial_port_cfg

// ===== verilog/pss_tx.sv
`timescale 1ns/1ps
module pss_tx (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_arst_n,
    // oversample tick and request
    input  wire logic       i_tick,
    input  wire logic       i_start,
    input  wire logic [7:0] i_data,
    // character format
    input  wire logic       i_data7,
    input  wire logic       i_par_en,
    input  wire logic       i_par_odd,
    input  wire logic       i_stop2,
    // line
    output logic            o_busy,
    output logic            o_txd
);
    import pss_pkg::*;
    typedef enum logic [2:0] {
        PSS_TX_IDLE = 3'b000, PSS_TX_START = 3'b001, PSS_TX_DATA = 3'b010,
        PSS_TX_PAR  = 3'b011, PSS_TX_STOP  = 3'b100
    } pss_tx_state_t;
    pss_tx_state_t state;
    logic [3:0] tick_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic       par_acc, stop_left;
    wire        cell_end = i_tick && tick_cnt == PSS_LAST_TICK;
    assign o_busy = state != PSS_TX_IDLE;
    // each cell lasts sixteen ticks; the line idles high
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= PSS_TX_IDLE;
            tick_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            par_acc <= 1'b0;
            stop_left <= 1'b0;
            o_txd <= 1'b1;
        end else begin
            if (i_tick && state != PSS_TX_IDLE) begin
                tick_cnt <= tick_cnt + 4'h1;
            end
            case (state)
                PSS_TX_IDLE: if (i_start) begin
                    state <= PSS_TX_START;
                    shift <= i_data;
                    par_acc <= i_par_odd;
                    tick_cnt <= 4'h0;
                    o_txd <= 1'b0;
                end
                PSS_TX_START: if (cell_end) begin
                    state <= PSS_TX_DATA;
                    bit_cnt <= 3'h0;
                    o_txd <= shift[0];
                end
                PSS_TX_DATA: if (cell_end) begin
                    par_acc <= par_acc ^ shift[0];
                    shift <= {1'b0, shift[7:1]};
                    bit_cnt <= bit_cnt + 3'h1;
                    stop_left <= i_stop2;
                    if (bit_cnt == (i_data7 ? 3'h6 : 3'h7)) begin
                        state <= i_par_en ? PSS_TX_PAR : PSS_TX_STOP;
                        o_txd <= i_par_en ? par_acc ^ shift[0] : 1'b1;
                    end else begin
                        o_txd <= shift[1];
                    end
                end
                PSS_TX_PAR: if (cell_end) begin
                    state <= PSS_TX_STOP;
                    o_txd <= 1'b1;
                end
                PSS_TX_STOP: if (cell_end) begin
                    if (stop_left) begin
                        stop_left <= 1'b0;
                    end else begin
                        state <= PSS_TX_IDLE;
                    end
                end
                default: state <= PSS_TX_IDLE;
            endcase
        end
    end
endmodule // pss_tx
